// ---- inc/bcp_pkg.sv ----
// constants, state codes and register map for the buck control sequencer
`default_nettype none
package bcp_pkg;

  // clock rate
  localparam int CLK_MHZ = 250;

  // times in their own units, cycle counts derived at the clock rate
  localparam int SS_TIME_US     = 1200;
  localparam int SS_CYC         = SS_TIME_US * CLK_MHZ;
  localparam int REF_STEPS      = 256;
  localparam int SS_STEP_CYC    = SS_CYC / REF_STEPS;
  localparam int PG_DELAY_US    = 64;
  localparam int PG_DELAY_CYC   = PG_DELAY_US * CLK_MHZ;
  localparam int UV_DELAY_US    = 32;
  localparam int UV_DELAY_CYC   = UV_DELAY_US * CLK_MHZ;
  localparam int UV_MASK_US     = 2000;
  localparam int UV_MASK_CYC    = UV_MASK_US * CLK_MHZ;
  localparam int NEG_RETRY_NS   = 400;
  localparam int NEG_RETRY_CYC  = (NEG_RETRY_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_NS        = 20;
  localparam int DEAD_CYC       = (DEAD_NS * CLK_MHZ + 999) / 1000;

  // synchronised input vector layout
  localparam int IN_EN_ON       = 0;
  localparam int IN_EN_HIGH     = 1;
  localparam int IN_FB_LOW      = 2;
  localparam int IN_FB_PG_IN    = 3;
  localparam int IN_FB_PG_OUT   = 4;
  localparam int IN_FB_OV       = 5;
  localparam int IN_FB_UV       = 6;
  localparam int IN_OUTPUT_SENSE_PIN_ABS    = 7;
  localparam int IN_I_TRIP      = 8;
  localparam int IN_I_REV       = 9;
  localparam int IN_I_ZERO      = 10;
  localparam int IN_ONT_DONE    = 11;
  localparam int IN_LOCKOUT     = 12;
  localparam int IN_OTP         = 13;
  localparam int IN_PG_PIN      = 14;
  localparam int IN_W           = 15;

  // register map, byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_REF    = 12'h008;
  localparam int          CTRL_RUN    = 0;
  localparam logic        CTRL_RUN_RST = 1'b1;

  // status fields
  localparam int ST_SW_LSB   = 0;
  localparam int ST_PG       = 3;
  localparam int ST_UV       = 4;
  localparam int ST_OV       = 5;
  localparam int ST_OTP      = 6;
  localparam int ST_LOCK     = 7;
  localparam int ST_SS_DONE  = 8;
  localparam int ST_FORCED   = 9;
  localparam int ST_EN       = 10;
  localparam int ST_PG_PIN   = 11;

  // switching sequence, gray along idle-dead-high-dead-low
  typedef enum logic [2:0] {
    SW_IDLE   = 3'h0,
    SW_DEAD_H = 3'h1,
    SW_HIGH   = 3'h3,
    SW_DEAD_L = 3'h2,
    SW_LOW    = 3'h6,
    SW_NEGOFF = 3'h7
  } bcp_sw_t;

endpackage : bcp_pkg
`default_nettype wire

// ---- rtl/bcp_sync.sv ----
// two-flop synchronisers for asynchronous comparator and pin inputs
`timescale 1ns/100ps
`default_nettype none
module bcp_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bcp_sync_state_t;

  bcp_sync_state_t r;
  bcp_sync_state_t next_r;

  // meta stage feeds only the stable stage
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        next_r.meta[i]   = async_in[i];
        next_r.stable[i] = r.meta[i];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;

endmodule : bcp_sync
`default_nettype wire

// ---- rtl/bcp_top.sv ----
// control and protection sequencer for a synchronous buck stage
`timescale 1ns/100ps
`default_nettype none
module bcp_top
#(
  parameter logic [19:0] SS_STEP   = 20'(bcp_pkg::SS_STEP_CYC),
  parameter logic [19:0] PG_DELAY  = 20'(bcp_pkg::PG_DELAY_CYC),
  parameter logic [19:0] UV_DELAY  = 20'(bcp_pkg::UV_DELAY_CYC),
  parameter logic [19:0] UV_MASK   = 20'(bcp_pkg::UV_MASK_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        enable_mode_select_pin_on,
  input  wire logic        enable_mode_select_pin_high,
  input  wire logic        feedback_voltage_below_ref,
  input  wire logic        feedback_voltage_in_window,
  input  wire logic        feedback_voltage_out_band,
  input  wire logic        feedback_voltage_over,
  input  wire logic        feedback_voltage_under,
  input  wire logic        output_sense_pin_over,
  input  wire logic        valley_current_limit,
  input  wire logic        reverse_current_limit,
  input  wire logic        switch_node_zero,
  input  wire logic        ontime_expired,
  input  wire logic        bias_supply_lockout,
  input  wire logic        over_temperature,
  input  wire logic        output_in_regulation_flag_i,
  output var  logic        output_in_regulation_flag_o,
  output var  logic        output_in_regulation_flag_oe,
  output var  logic        high_gate_drive,
  output var  logic        low_gate_drive,
  output var  logic        discharge_enable,
  output var  logic        ontime_start,
  output var  logic [7:0]  soft_start_ref
);
  import bcp_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    bcp_sw_t     sw;
    logic [7:0]  swc;
    logic [7:0]  ref_code;
    logic [19:0] ss_cnt;
    logic        ss_done;
    logic [19:0] pg_cnt;
    logic        pg;
    logic [19:0] uvm_cnt;
    logic        uv_armed;
    logic [19:0] uv_cnt;
    logic        uv_latched;
    logic        hi;
    logic        lo;
    logic        dis;
    logic        trig;
    logic        pg_level;
    logic        pg_pull;
    logic        run_allow;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } bcp_top_state_t;

  bcp_top_state_t r;
  bcp_top_state_t next_r;

  localparam logic [7:0] DEAD_C = 8'(DEAD_CYC);
  localparam logic [7:0] NEG_C  = 8'(NEG_RETRY_CYC);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisation
  logic [IN_W-1:0] raw;
  logic [IN_W-1:0] s;

  assign raw = {output_in_regulation_flag_i, over_temperature,
                bias_supply_lockout, ontime_expired, switch_node_zero,
                reverse_current_limit, valley_current_limit,
                output_sense_pin_over, feedback_voltage_under,
                feedback_voltage_over, feedback_voltage_out_band,
                feedback_voltage_in_window, feedback_voltage_below_ref,
                enable_mode_select_pin_high, enable_mode_select_pin_on};

  bcp_sync #(
    .W        (IN_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (raw),
    .sync_out (s)
  );

  logic en;
  logic forced;
  logic lock;
  logic otp;
  logic overvoltage_fault;
  logic vabs;
  logic active;
  logic halt;
  logic start_ok;
  logic acc;
  logic [31:0] status;

  assign en     = s[IN_EN_ON];
  assign forced = s[IN_EN_ON] & ~s[IN_EN_HIGH];
  assign lock   = s[IN_LOCKOUT];
  assign otp    = s[IN_OTP];
  assign overvoltage_fault    = s[IN_FB_OV];
  assign vabs   = s[IN_OUTPUT_SENSE_PIN_ABS];
  assign acc    = psel & penable & ~r.pready;

  // lockout acts as reset, restart follows
  assign active = en & ~lock;
  assign halt   = ~active | otp | r.uv_latched | ~r.run_allow;

  // feedback low and current under limit
  // valley limit postpones the next on
  assign start_ok = s[IN_FB_LOW] & ~s[IN_I_TRIP] & ~vabs & ~overvoltage_fault;

  always_comb begin
    status = '0;
    status[ST_SW_LSB +: 3] = r.sw;
    status[ST_PG]      = r.pg;
    status[ST_UV]      = r.uv_latched;
    status[ST_OV]      = overvoltage_fault;
    status[ST_OTP]     = otp;
    status[ST_LOCK]    = lock;
    status[ST_SS_DONE] = r.ss_done;
    status[ST_FORCED]  = forced;
    status[ST_EN]      = en;
    status[ST_PG_PIN]  = s[IN_PG_PIN];
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r      = r;
    next_r.trig = 1'b0;

    // apb: one wait cycle, answer registered
    next_r.pready  = acc;
    next_r.pslverr = 1'b0;
    next_r.prdata  = '0;
    if (acc) begin
      unique case (paddr)
        ADDR_CTRL:   next_r.prdata[CTRL_RUN] = r.run_allow;
        ADDR_STATUS: next_r.prdata = status;
        ADDR_REF:    next_r.prdata[7:0] = r.ref_code;
        default:     next_r.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && r.pready && pwrite && paddr == ADDR_CTRL &&
        pstrb[0]) begin
      next_r.run_allow = pwdata[CTRL_RUN];
    end

    if (!active) begin
      // disable or lockout clears the latch
      next_r.ss_cnt     = '0;
      next_r.ref_code   = '0;
      next_r.ss_done    = 1'b0;
      next_r.pg_cnt     = '0;
      next_r.pg         = 1'b0;
      next_r.uvm_cnt    = '0;
      next_r.uv_armed   = 1'b0;
      next_r.uv_cnt     = '0;
      next_r.uv_latched = 1'b0;
    end else begin
      if (!r.ss_done) begin
        if (r.ss_cnt >= SS_STEP - 20'h1) begin
          next_r.ss_cnt = '0;
          if (r.ref_code == 8'hff) begin
            next_r.ss_done = 1'b1;
          end else begin
            next_r.ref_code = r.ref_code + 8'h1;
          end
        end else begin
          next_r.ss_cnt = r.ss_cnt + 20'h1;
        end
      end

      if (!r.uv_armed) begin
        if (r.uvm_cnt >= UV_MASK - 20'h1) begin
          next_r.uv_armed = 1'b1;
        end else begin
          next_r.uvm_cnt = r.uvm_cnt + 20'h1;
        end
      end

      if (r.uv_armed && s[IN_FB_UV] && !r.uv_latched) begin
        if (r.uv_cnt >= UV_DELAY - 20'h1) begin
          next_r.uv_latched = 1'b1;
        end else begin
          next_r.uv_cnt = r.uv_cnt + 20'h1;
        end
      end else if (!s[IN_FB_UV]) begin
        next_r.uv_cnt = '0;
      end

      if (!r.ss_done || s[IN_FB_PG_OUT] || r.uv_latched || overvoltage_fault || otp) begin
        next_r.pg     = 1'b0;
        next_r.pg_cnt = '0;
      end else if (!r.pg) begin
        if (!s[IN_FB_PG_IN]) begin
          next_r.pg_cnt = '0;
        end else if (r.pg_cnt >= PG_DELAY - 20'h1) begin
          next_r.pg = 1'b1;
        end else begin
          next_r.pg_cnt = r.pg_cnt + 20'h1;
        end
      end
    end

    //////////////////////////////////////////////////////////////////////
    // switching sequence
    if (r.swc != 8'h0) begin
      next_r.swc = r.swc - 8'h1;
    end
    if (halt) begin
      next_r.sw  = SW_IDLE;
      next_r.swc = DEAD_C;
    end else begin
      unique case (r.sw)
        SW_IDLE: begin
          // overvoltage forces low on, after dead time
          if (overvoltage_fault) begin
            next_r.sw = SW_DEAD_L;
          end else if (start_ok) begin
            next_r.sw  = SW_DEAD_H;
            next_r.swc = DEAD_C;
          end
        end
        SW_DEAD_H: begin
          if (overvoltage_fault) begin
            next_r.sw = SW_DEAD_L;
          end else if (r.swc == 8'h0 && !vabs) begin
            // cycle opens with high side on
            next_r.sw   = SW_HIGH;
            next_r.trig = 1'b1;
          end
        end
        SW_HIGH: begin
          if (s[IN_ONT_DONE] || overvoltage_fault || vabs) begin
            next_r.sw  = SW_DEAD_L;
            next_r.swc = DEAD_C;
          end
        end
        SW_DEAD_L: begin
          if (r.swc == 8'h0) begin
            next_r.sw = SW_LOW;
          end
        end
        SW_LOW: begin
          if (overvoltage_fault) begin
            next_r.sw = SW_LOW;
          // reverse limit only in forced mode
          end else if (forced && s[IN_I_REV]) begin
            next_r.sw  = SW_NEGOFF;
            next_r.swc = NEG_C;
          // skip mode stops at zero current
          end else if (!forced && s[IN_I_ZERO]) begin
            next_r.sw = SW_IDLE;
          // target reached: low off, high next
          end else if (start_ok) begin
            next_r.sw  = SW_DEAD_H;
            next_r.swc = DEAD_C;
          end
        end
        SW_NEGOFF: begin
          if (overvoltage_fault) begin
            next_r.sw = SW_LOW;
          end else if (start_ok) begin
            next_r.sw  = SW_DEAD_H;
            next_r.swc = DEAD_C;
          // low back on after retry gap
          end else if (r.swc == 8'h0) begin
            next_r.sw = SW_LOW;
          end
        end
        default: begin
          next_r.sw = SW_IDLE;
        end
      endcase
    end

    next_r.hi = (next_r.sw == SW_HIGH);
    next_r.lo = (next_r.sw == SW_LOW);
    // discharge on disable, lockout, overtemperature, feedback overvoltage or latched undervoltage
    next_r.dis = ~en | lock | otp | overvoltage_fault | r.uv_latched;
    // open drain pin only ever pulls low
    next_r.pg_level = 1'b0;
    next_r.pg_pull  = ~next_r.pg;
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r           <= '0;
      r.sw        <= SW_IDLE;
      r.run_allow <= CTRL_RUN_RST;
      r.pg_pull   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata                       = r.prdata;
  assign pready                       = r.pready;
  assign pslverr                      = r.pslverr;
  assign high_gate_drive              = r.hi;
  assign low_gate_drive               = r.lo;
  assign discharge_enable             = r.dis;
  assign ontime_start                 = r.trig;
  assign soft_start_ref               = r.ref_code;
  assign output_in_regulation_flag_o  = r.pg_level;
  assign output_in_regulation_flag_oe = r.pg_pull;

endmodule : bcp_top
`default_nettype wire

// ---- test/bcp_stage.sv ----
// behavioural buck power stage: one-shot, zero and reverse current sense
`timescale 1ns/100ps
`default_nettype none
module bcp_stage (
  input  wire logic pclk,
  input  wire logic high_gate_drive,
  input  wire logic low_gate_drive,
  input  wire logic sink,
  input  wire logic flag_oe,
  output var  logic ontime_expired,
  output var  logic switch_node_zero,
  output var  logic reverse_current_limit,
  output var  logic flag_pin
);
  logic [7:0] conduct;

  // time since a switch closed; saturates so a long low-side stays sane
  always_ff @(posedge pclk) begin
    if (!(high_gate_drive || low_gate_drive)) begin
      conduct <= 8'h00;
    end else if (conduct != 8'hff) begin
      conduct <= conduct + 8'h01;
    end
  end

  assign ontime_expired = high_gate_drive && conduct >= 8'h0c;
  assign switch_node_zero = low_gate_drive && conduct >= 8'h1e;
  // a sinking load pushes the current negative later in the off-interval
  assign reverse_current_limit = low_gate_drive && sink && conduct >= 8'h3c;
  // open-drain flag with pull-up
  assign flag_pin = !flag_oe;
endmodule : bcp_stage
`default_nettype wire

// ---- test/bcp_top_chk.sv ----
// port assertions for the buck control sequencer
`timescale 1ns/100ps
`default_nettype none
module bcp_top_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       enable_mode_select_pin_on,
  input wire logic       feedback_voltage_out_band,
  input wire logic       feedback_voltage_over,
  input wire logic       output_sense_pin_over,
  input wire logic       bias_supply_lockout,
  input wire logic       over_temperature,
  input wire logic       output_in_regulation_flag_oe,
  input wire logic       high_gate_drive,
  input wire logic       low_gate_drive,
  input wire logic       discharge_enable,
  input wire logic       ontime_start,
  input wire logic [7:0] soft_start_ref
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_dead_h;
    $fell(low_gate_drive) |=> !high_gate_drive [*5];
  endproperty
  a_dead_h: assert property (p_dead_h)
    else $error("high side on inside dead time");
  property p_dead_l;
    $fell(high_gate_drive) |=> !low_gate_drive [*5];
  endproperty
  a_dead_l: assert property (p_dead_l)
    else $error("low side on inside dead time");
  property p_overlap;
    !(high_gate_drive && low_gate_drive);
  endproperty
  a_overlap: assert property (p_overlap)
    else $error("both gates on");
  property p_ontime;
    $rose(high_gate_drive) |-> ontime_start;
  endproperty
  a_ontime: assert property (p_ontime)
    else $error("high side on without one-shot start");
  // synchroniser depth plus one register
  property p_disch;
    (!enable_mode_select_pin_on || bias_supply_lockout || over_temperature
      || feedback_voltage_over) [*3] |=> discharge_enable;
  endproperty
  a_disch: assert property (p_disch)
    else $error("discharge off while disabled or faulted");
  property p_ov_high;
    (feedback_voltage_over || output_sense_pin_over) [*3] |=> !high_gate_drive;
  endproperty
  a_ov_high: assert property (p_ov_high)
    else $error("high side on during overvoltage");
  property p_pg_drop;
    feedback_voltage_out_band [*3] |=> output_in_regulation_flag_oe;
  endproperty
  a_pg_drop: assert property (p_pg_drop)
    else $error("flag good while out of band");
  property p_pg_ss;
    soft_start_ref != 8'hff |-> output_in_regulation_flag_oe;
  endproperty
  a_pg_ss: assert property (p_pg_ss)
    else $error("flag good during ramp");

  c_high: cover property ($rose(high_gate_drive));
  c_pg: cover property ($fell(output_in_regulation_flag_oe));
  c_disch: cover property ($rose(discharge_enable));
endmodule : bcp_top_chk

bind bcp_top bcp_top_chk bcp_top_chk_inst (
  .pclk, .presetn, .enable_mode_select_pin_on, .feedback_voltage_out_band,
  .feedback_voltage_over, .output_sense_pin_over, .bias_supply_lockout,
  .over_temperature, .output_in_regulation_flag_oe, .high_gate_drive,
  .low_gate_drive, .discharge_enable, .ontime_start, .soft_start_ref
);
`default_nettype wire

// ---- test/bcp_top_tb_top.sv ----
// self-checking bench for the buck control sequencer
`timescale 1ns/100ps
`default_nettype none
module bcp_top_tb_top;
  import bcp_pkg::*;
  localparam int SSP = 4;
  localparam int PGD = 20;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, sink = 1'h0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  lf = 8'h16, sref;
  logic        en = 1'h0, hi = 1'h0, blw = 1'h0, win = 1'h0, oob = 1'h0;
  logic        ovr = 1'h0, und = 1'h0, vov = 1'h0, val = 1'h0, lck = 1'h0;
  logic        otp = 1'h0, ote, zro, rev, pgi, gh, gl, dis, oe, pgo;
  int          fails = 0, check_count = 0, cyc = 0, n;

  initial forever #2 pclk = ~pclk;

  bcp_top #(.SS_STEP(20'(SSP)), .PG_DELAY(20'(PGD)), .UV_DELAY(20'h0000a),
    .UV_MASK(20'h00032)) bcp_top_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr,
    .enable_mode_select_pin_on(en), .enable_mode_select_pin_high(hi),
    .feedback_voltage_below_ref(blw), .feedback_voltage_in_window(win),
    .feedback_voltage_out_band(oob), .feedback_voltage_over(ovr),
    .feedback_voltage_under(und), .output_sense_pin_over(vov),
    .valley_current_limit(val), .reverse_current_limit(rev),
    .switch_node_zero(zro), .ontime_expired(ote),
    .bias_supply_lockout(lck), .over_temperature(otp),
    .output_in_regulation_flag_i(pgi), .output_in_regulation_flag_o(pgo),
    .output_in_regulation_flag_oe(oe), .high_gate_drive(gh),
    .low_gate_drive(gl), .discharge_enable(dis), .ontime_start(),
    .soft_start_ref(sref));

  bcp_stage bcp_stage_inst (.pclk, .high_gate_drive(gh), .low_gate_drive(gl),
    .sink, .flag_oe(oe), .ontime_expired(ote), .switch_node_zero(zro),
    .reverse_current_limit(rev), .flag_pin(pgi));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // tolerance covers the two-flop input latency
  function automatic logic near(input int v, input int e, input int t);
    return v >= e - t && v <= e + t;
  endfunction : near

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test;
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask : wt

  task automatic till(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge pclk);
  endtask : till

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      end_of_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    wt(20);
    chk(32'({gh, gl, oe}), 32'h1);
    presetn <= 1'h1;
    apb(1'h0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    lf = lfsr(lf);
    apb(1'h0, 12'h100 | {2'h0, lf, 2'h0}, 32'h0);
    chk(32'({err, rd != 32'h0}), 32'h2);
    en <= 1'h1;
    hi <= 1'h1;
    blw <= 1'h1;
    wt(200);
    chk(32'({near(int'(sref), 200 / SSP, 3), oe, dis}), 32'h6);
    for (n = 0; n < 1200 && sref !== 8'hff; n++) @(posedge pclk);
    chk(32'(near(n + 200, 256 * SSP, 8)), 32'h1);
    wt(10);
    win <= 1'h1;
    @(posedge pclk);
    till(oe, 1'h0, 100);
    chk(32'(near(n, PGD + 2, 3)), 32'h1);
    chk(32'({pgo, pgi}), 32'h1);
    oob <= 1'h1;
    wt(4);
    chk(32'(oe), 32'h1);
    oob <= 1'h0;
    win <= 1'h0;
    blw <= 1'h0;
    till(gl, 1'h1, 60);
    chk(32'(gl), 32'h1);
    till(gl, 1'h0, 60);
    wt(20);
    chk(32'({gh, gl}), 32'h0);
    val <= 1'h1;
    blw <= 1'h1;
    till(gh, 1'h1, 40);
    chk(32'(gh), 32'h0);
    val <= 1'h0;
    till(gh, 1'h1, 30);
    chk(32'(gh), 32'h1);
    hi <= 1'h0;
    blw <= 1'h0;
    till(gl, 1'h1, 60);
    wt(45);
    chk(32'(gl), 32'h1);
    sink <= 1'h1;
    till(gl, 1'h0, 40);
    chk(32'(gl), 32'h0);
    till(gl, 1'h1, 200);
    chk(32'(near(n, NEG_RETRY_CYC, 2)), 32'h1);
    till(gl, 1'h0, 100);
    chk(32'(gl), 32'h0);
    sink <= 1'h0;
    blw <= 1'h1;
    till(gh, 1'h1, 150);
    chk(32'({gh, gl}), 32'h2);
    ovr <= 1'h1;
    wt(14);
    chk(32'({gh, gl, dis}), 32'h3);
    ovr <= 1'h0;
    vov <= 1'h1;
    wt(4);
    till(gh, 1'h1, 40);
    chk(32'(gh), 32'h0);
    vov <= 1'h0;
    // a dip shorter than the qualification must not latch
    und <= 1'h1;
    wt(8);
    und <= 1'h0;
    wt(4);
    chk(32'(dis), 32'h0);
    und <= 1'h1;
    wt(16);
    chk(32'({gh, gl, dis}), 32'h1);
    und <= 1'h0;
    wt(10);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'({rd[ST_UV], dis}), 32'h3);
    en <= 1'h0;
    wt(6);
    chk(32'(dis), 32'h1);
    en <= 1'h1;
    und <= 1'h1;
    wt(30);
    und <= 1'h0;
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(32'({rd[ST_UV], sref < 8'h10}), 32'h1);
    for (int k = 0; k < 2; k++) begin
      lck <= 1'(k == 0);
      otp <= 1'(k == 1);
      wt(6);
      chk(32'({gh, gl, dis}), 32'h1);
      lck <= 1'h0;
      otp <= 1'h0;
      till(gh, 1'h1, 80);
      chk(32'(gh), 32'h1);
    end
    lf = lfsr(lf);
    apb(1'h1, ADDR_CTRL, {lf, 24'h0});
    wt(12);
    till(gh, 1'h1, 40);
    chk(32'({gh, gl}), 32'h0);
    apb(1'h1, ADDR_CTRL, {24'h0, lf} | 32'h1);
    till(gh, 1'h1, 80);
    chk(32'(gh), 32'h1);
    end_of_test();
  end
endmodule : bcp_top_tb_top
`default_nettype wire
